/* clid_pkg.sv */
/*
   Shared constants and types of the character display instruction decoder.
   Assumes a 125 MHz core clock; all counts are derived from it.
*/
package clid_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int EXEC_SHORT_NS = 38000;
   localparam int EXEC_LONG_NS = 1520000;
   localparam int BLINK_HALF_NS = 400000000;
   localparam int EXEC_SHORT_CYCLES =
      (EXEC_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXEC_LONG_CYCLES =
      (EXEC_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLINK_HALF_CYCLES = BLINK_HALF_NS / CLK_PERIOD_NS;
   localparam int COUNT_W = 26;

   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = 10;
   localparam int WORD_RS = 9;
   localparam int WORD_RW = 8;

   localparam int BIT_FONT = 2;
   localparam int BIT_LINES = 3;
   localparam int BIT_WIDTH = 4;
   localparam int BIT_SEL = 3;
   localparam int BIT_DIR = 2;

   localparam logic [6:0] ONE_LINE_LAST = 7'h4f;
   localparam logic [6:0] LINE1_LAST = 7'h27;
   localparam logic [6:0] LINE2_FIRST = 7'h40;
   localparam logic [6:0] LINE2_LAST = 7'h67;
   localparam logic [6:0] LEN_ONE_LINE = 7'h50;
   localparam logic [6:0] LEN_TWO_LINE = 7'h28;
   localparam logic [6:0] TEXT_TOP = 7'h7f;
   localparam logic [7:0] SPACE_CODE = 8'h20;
   localparam logic [7:0] CMD_CLEAR = 8'h01;

   localparam logic RST_WIDTH8 = 1'b1;
   localparam logic RST_INCR = 1'b1;
   localparam logic [6:0] RST_ADDR = 7'h00;

   typedef enum logic {EX_IDLE, EX_RUN} clid_exec_t;
endpackage

/* clid_fifo_if.sv */
/*
   Valid/ready carrier between the decoder front end, its queue and the
   executor. Assumes one clock domain on both sides.
*/
`timescale 1ns/1ns
`default_nettype none
interface clid_fifo_if #(parameter int W = 10);
   logic inValid;
   logic inReady;
   logic [W-1:0] inData;
   logic outValid;
   logic outReady;
   logic [W-1:0] outData;
   modport producer (output inValid, output inData, input inReady);
   modport store (input inValid, input inData, output inReady,
      output outValid, output outData, input outReady);
   modport consumer (input outValid, input outData, output outReady);
endinterface
`default_nettype wire

/* clid_fifo.sv */
/*
   Instruction queue with parameterised width and depth.
   Assumes an asynchronous active-low reset already released cleanly.
*/
`timescale 1ns/1ns
`default_nettype none
module clid_fifo
   import clid_pkg::*;
#(
   parameter int W = 10,
   parameter int DEPTH = 16
)
(
   input wire logic core_clk,
   input wire logic rstN,
   clid_fifo_if.store q
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_reg;
   logic [AW:0] rdPtr_reg;
   wire full = (wrPtr_reg[AW] != rdPtr_reg[AW])
      && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
   wire empty = (wrPtr_reg == rdPtr_reg);
   wire doPush = q.inValid && !full;
   wire doPop = q.outReady && !empty;

   assign q.inReady = !full;
   assign q.outValid = !empty;
   assign q.outData = mem[rdPtr_reg[AW-1:0]];

   always_ff @(posedge core_clk)
   begin
      if (doPush)
      begin
         mem[wrPtr_reg[AW-1:0]] <= q.inData;
      end
   end

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
      end
      else
      begin
         wrPtr_reg <= wrPtr_reg + (AW+1)'(doPush);
         rdPtr_reg <= rdPtr_reg + (AW+1)'(doPop);
      end
   end
endmodule
`default_nettype wire

/* clid_decoder.sv */
/*
   Instruction decoder of a character dot-matrix display controller: host
   bus front end, instruction queue, executor, text and glyph memories.
   Assumes host strobes are one-cycle pulses synchronous to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module clid_decoder
   import clid_pkg::*;
#(
   parameter int SHORT_CYCLES = EXEC_SHORT_CYCLES,
   parameter int LONG_CYCLES = EXEC_LONG_CYCLES,
   parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
)
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic hostStrobe,
   input wire logic registerSelect,
   input wire logic readNotWrite,
   input wire logic [7:0] hostDataIn,
   output logic [7:0] hostDataOut,
   output logic hostDataOe,
   output logic busyFlag,
   output logic queueFull,
   output logic displayBlank,
   output logic cursorVisible,
   output logic cursorCellAllOn,
   output logic twoLineMode,
   output logic bigFont,
   output logic busWidthSelect,
   output logic [6:0] shiftOffset,
   input wire logic [6:0] scanAddr,
   output logic [7:0] scanChar,
   input wire logic [7:0] glyphCode,
   input wire logic [2:0] glyphRowSel,
   output logic [4:0] glyphRowBits,
   output logic glyphHit
);
   logic rstMeta_reg;
   logic rstN;
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rstMeta_reg <= 1'b0;
         rstN <= 1'b0;
      end
      else
      begin
         rstMeta_reg <= 1'b1;
         rstN <= rstMeta_reg;
      end
   end

   // Steps a text address inside the window of the current line mode.
   // line windows
   function automatic logic [6:0] stepText(input logic [6:0] a,
      input logic up, input logic two);
      logic [6:0] r;
      r = up ? a + 7'h01 : a - 7'h01;
      if (!two && up && a >= ONE_LINE_LAST) r = RST_ADDR;
      if (!two && !up && (a == RST_ADDR || a > ONE_LINE_LAST))
         r = ONE_LINE_LAST;
      if (two && up && a == LINE1_LAST) r = LINE2_FIRST;
      if (two && up && a >= LINE2_LAST) r = RST_ADDR;
      if (two && !up && a == LINE2_FIRST) r = LINE1_LAST;
      if (two && !up && a == RST_ADDR) r = LINE2_LAST;
      return r;
   endfunction

   // Moves the display window by one cell, modulo the line length.
   function automatic logic [6:0] stepWindow(input logic [6:0] o,
      input logic left, input logic two);
      logic [6:0] last;
      last = (two ? LEN_TWO_LINE : LEN_ONE_LINE) - 7'h01;
      if (left) return (o >= last) ? 7'h00 : o + 7'h01;
      return (o == 7'h00 || o > last) ? last : o - 7'h01;
   endfunction

   clid_fifo_if #(.W(FIFO_W)) qbus ();
   clid_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_queue (
      .core_clk(core_clk),
      .rstN(rstN),
      .q(qbus.store)
   );

   logic [7:0] textRam [128];
   logic [7:0] glyphRam [64];
   clid_exec_t exState_reg;
   logic [COUNT_W-1:0] exCount_reg;
   logic [6:0] clearIdx_reg;
   logic clearing_reg;
   logic reload_reg;
   logic [6:0] addrCnt_reg;
   logic glyphSel_reg;
   logic incr_reg;
   logic entryShift_reg;
   logic dispOn_reg;
   logic cursorOn_reg;
   logic blinkOn_reg;
   logic width8_reg;
   logic twoLine_reg;
   logic font_reg;
   logic [6:0] offset_reg;
   logic [7:0] outData_reg;
   logic nibblePhase_reg;
   logic [3:0] hiNibble_reg;
   logic [7:0] readHold_reg;
   logic [COUNT_W-1:0] blinkCount_reg;
   logic blinkPhase_reg;

   // Host side: a byte is complete on any 8-bit strobe or a second nibble.
   wire statusRead = !registerSelect && readNotWrite;
   wire byteDone = width8_reg || nibblePhase_reg;
   wire [7:0] wrByte = width8_reg ? hostDataIn
      : {hiNibble_reg, hostDataIn[7:4]};
   wire [7:0] rdValue = statusRead ? {busyFlag, addrCnt_reg} : outData_reg;
   wire [7:0] rdDrive = width8_reg ? rdValue
      : nibblePhase_reg ? {readHold_reg[3:0], 4'h0} : {rdValue[7:4], 4'h0};
   assign qbus.inValid = hostStrobe && byteDone && !statusRead;
   assign qbus.inData = {registerSelect, readNotWrite, wrByte};

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         nibblePhase_reg <= 1'b0;
         hiNibble_reg <= 4'h0;
         readHold_reg <= 8'h00;
         hostDataOut <= 8'h00;
         hostDataOe <= 1'b0;
      end
      else
      begin
         hostDataOe <= readNotWrite && (hostStrobe || hostDataOe);
         if (hostStrobe)
         begin
            nibblePhase_reg <= !width8_reg && !nibblePhase_reg;
            if (!nibblePhase_reg)
            begin
               hiNibble_reg <= hostDataIn[7:4];
               readHold_reg <= rdValue;
            end
            if (readNotWrite)
            begin
               // busy and counter on status read
               hostDataOut <= rdDrive;
            end
         end
      end
   end

   // Executor: one queued instruction at a time, held for its run time.
   wire fire = qbus.outValid && (exState_reg == EX_IDLE);
   assign qbus.outReady = (exState_reg == EX_IDLE);
   wire [7:0] opd = qbus.outData[7:0];
   wire opRs = qbus.outData[WORD_RS];
   wire opRw = qbus.outData[WORD_RW];
   wire isDataWr = fire && opRs && !opRw;
   wire isDataRd = fire && opRs && opRw;
   wire isCmd = fire && !opRs;
   wire isTextSet = isCmd && opd[7];
   wire isGlyphSet = isCmd && opd[7:6] == 2'b01;
   wire isFunc = isCmd && opd[7:5] == 3'b001;
   wire isShift = isCmd && opd[7:4] == 4'b0001;
   wire isDisp = isCmd && opd[7:3] == 5'b00001;
   wire isEntry = isCmd && opd[7:2] == 6'b000001;
   wire isHome = isCmd && opd[7:1] == 7'b0000001;
   wire isClear = isCmd && opd == CMD_CLEAR;
   wire isLong = isHome || isClear;
   wire [6:0] entryStep = glyphSel_reg
      ? {1'b0, incr_reg ? addrCnt_reg[5:0] + 6'h01 : addrCnt_reg[5:0] - 6'h01}
      : stepText(addrCnt_reg, incr_reg, twoLine_reg);
   wire [6:0] cursorStep = stepText(addrCnt_reg, opd[BIT_DIR], twoLine_reg);
   wire [7:0] ramRead = glyphSel_reg ? glyphRam[addrCnt_reg[5:0]]
      : textRam[addrCnt_reg];
   wire runDone = (exState_reg == EX_RUN) && exCount_reg == COUNT_W'(1);

   wire busyNext = qbus.inValid || qbus.outValid || (exState_reg == EX_RUN)
      && !runDone;

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         exState_reg <= EX_IDLE;
         exCount_reg <= '0;
         busyFlag <= 1'b0;
         queueFull <= 1'b0;
      end
      else
      begin
         busyFlag <= busyNext;
         queueFull <= !qbus.inReady;
         if (fire)
         begin
            exState_reg <= EX_RUN;
            exCount_reg <= isLong ? COUNT_W'(LONG_CYCLES)
               : COUNT_W'(SHORT_CYCLES);
         end
         else if (runDone)
         begin
            exState_reg <= EX_IDLE;
         end
         else if (exState_reg == EX_RUN)
         begin
            exCount_reg <= exCount_reg - COUNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         addrCnt_reg <= RST_ADDR;
         glyphSel_reg <= 1'b0;
         offset_reg <= 7'h00;
         reload_reg <= 1'b0;
         outData_reg <= 8'h00;
      end
      else
      begin
         if (isTextSet)
            addrCnt_reg <= opd[6:0];
         else if (isGlyphSet)
            addrCnt_reg <= {1'b0, opd[5:0]};
         else if (isHome || isClear)
            addrCnt_reg <= RST_ADDR;
         else if (isShift && !opd[BIT_SEL])
            addrCnt_reg <= glyphSel_reg ? entryStep : cursorStep;
         else if (isDataWr || isDataRd)
            addrCnt_reg <= entryStep;
         if (isTextSet || isHome || isClear)
            glyphSel_reg <= 1'b0;
         else if (isGlyphSet)
            glyphSel_reg <= 1'b1;
         // display shift moves only the shared window
         if (isShift && opd[BIT_SEL])
            offset_reg <= stepWindow(offset_reg, !opd[BIT_DIR], twoLine_reg);
         else if (isDataWr && !glyphSel_reg && entryShift_reg)
            offset_reg <= stepWindow(offset_reg, incr_reg, twoLine_reg);
         else if (isHome || isClear)
            offset_reg <= 7'h00;
         // latch data only on set, text cursor shift or read
         if (isTextSet || isGlyphSet || isDataRd
            || isShift && !opd[BIT_SEL] && !glyphSel_reg)
            reload_reg <= 1'b1;
         else if (runDone)
            reload_reg <= 1'b0;
         if (runDone && reload_reg)
            outData_reg <= ramRead;
      end
   end

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         incr_reg <= RST_INCR;
         entryShift_reg <= 1'b0;
         dispOn_reg <= 1'b0;
         cursorOn_reg <= 1'b0;
         blinkOn_reg <= 1'b0;
         width8_reg <= RST_WIDTH8;
         twoLine_reg <= 1'b0;
         font_reg <= 1'b0;
      end
      else
      begin
         if (isEntry)
         begin
            incr_reg <= opd[1];
            entryShift_reg <= opd[0];
         end
         else if (isClear)
            incr_reg <= 1'b1;
         if (isDisp)
         begin
            dispOn_reg <= opd[2];
            cursorOn_reg <= opd[1];
            blinkOn_reg <= opd[0];
         end
         if (isFunc)
         begin
            width8_reg <= opd[BIT_WIDTH];
            twoLine_reg <= opd[BIT_LINES];
            font_reg <= opd[BIT_FONT];
         end
      end
   end

   // Clearing walks the whole text store while the long run time elapses,
   // so LONG_CYCLES must exceed the store size.
   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         clearing_reg <= 1'b0;
         clearIdx_reg <= 7'h00;
      end
      else if (isClear)
      begin
         clearing_reg <= 1'b1;
         clearIdx_reg <= 7'h00;
      end
      else if (clearing_reg)
      begin
         clearing_reg <= clearIdx_reg != TEXT_TOP;
         clearIdx_reg <= clearIdx_reg + 7'h01;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (clearing_reg)
         textRam[clearIdx_reg] <= SPACE_CODE;
      else if (isDataWr && !glyphSel_reg)
         textRam[addrCnt_reg] <= opd;
      if (isDataWr && glyphSel_reg)
         glyphRam[addrCnt_reg[5:0]] <= opd;
   end

   // user glyph lookup, code bit 3 ignored
   wire glyphMatch = glyphCode[7:4] == 4'h0;
   wire [5:0] glyphAddr = {glyphCode[2:0], glyphRowSel};

   always_ff @(posedge core_clk or negedge rstN)
   begin
      if (!rstN)
      begin
         blinkCount_reg <= '0;
         blinkPhase_reg <= 1'b0;
         displayBlank <= 1'b1;
         cursorVisible <= 1'b0;
         cursorCellAllOn <= 1'b0;
         twoLineMode <= 1'b0;
         bigFont <= 1'b0;
         busWidthSelect <= RST_WIDTH8;
         shiftOffset <= 7'h00;
         scanChar <= 8'h00;
         glyphRowBits <= 5'h00;
         glyphHit <= 1'b0;
      end
      else
      begin
         // blink phase runs only while blinking is on
         if (!blinkOn_reg || blinkCount_reg == COUNT_W'(BLINK_CYCLES - 1))
            blinkCount_reg <= '0;
         else
            blinkCount_reg <= blinkCount_reg + COUNT_W'(1);
         if (!blinkOn_reg)
            blinkPhase_reg <= 1'b0;
         else if (blinkCount_reg == COUNT_W'(BLINK_CYCLES - 1))
            blinkPhase_reg <= !blinkPhase_reg;
         displayBlank <= !dispOn_reg;
         cursorVisible <= dispOn_reg && cursorOn_reg;
         cursorCellAllOn <= dispOn_reg && blinkOn_reg && blinkPhase_reg;
         twoLineMode <= twoLine_reg;
         bigFont <= font_reg;
         busWidthSelect <= width8_reg;
         shiftOffset <= offset_reg;
         scanChar <= textRam[scanAddr];
         glyphRowBits <= glyphMatch ? glyphRam[glyphAddr][4:0] : 5'h00;
         glyphHit <= glyphMatch;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstN);

   sequence s_dispCmd;
      isDisp ##1 1'b1;
   endsequence
   sequence s_wrap27;
      isDataWr && twoLine_reg && incr_reg && !glyphSel_reg
         && addrCnt_reg == LINE1_LAST;
   endsequence

   a_display_blank: assert property (s_dispCmd |=>
      displayBlank == !$past(opd[2], 2))
      else $error("display blank does not follow enable bit");
   a_cursor_keeps_dir: assert property (isDisp |=>
      incr_reg == $past(incr_reg))
      else $error("cursor command changed direction");
   a_blink_off: assert property (!blinkOn_reg ##1 !blinkOn_reg |=>
      !cursorCellAllOn)
      else $error("cursor cell lit with blink off");
   a_shift_keeps_ac: assert property (isShift && opd[BIT_SEL] |=>
      addrCnt_reg == $past(addrCnt_reg))
      else $error("display shift moved the counter");
   a_cursor_right: assert property (isShift && opd[3:2] == 2'b01
      && !glyphSel_reg && !twoLine_reg && addrCnt_reg < ONE_LINE_LAST
      |=> addrCnt_reg == $past(addrCnt_reg) + 7'h01)
      else $error("cursor right did not increment");
   a_line_wrap: assert property (s_wrap27 |=>
      addrCnt_reg == LINE2_FIRST)
      else $error("two-line wrap missed second line");
   a_one_line_wrap: assert property ((isDataRd || isDataWr) && !twoLine_reg
      && incr_reg && !glyphSel_reg && addrCnt_reg == ONE_LINE_LAST
      |=> addrCnt_reg == RST_ADDR)
      else $error("one-line wrap failed");
   a_status_read: assert property (hostStrobe && statusRead
      && width8_reg |=> hostDataOut == $past({busyFlag, addrCnt_reg}))
      else $error("status read returned wrong value");
   a_busy_hold: assert property (fire |=> busyFlag [*2])
      else $error("busy dropped right after acceptance");
   a_nibble_pair: assert property (hostStrobe && !width8_reg
      && !nibblePhase_reg |-> !qbus.inValid)
      else $error("first nibble pushed as a byte");
endmodule
`default_nettype wire

/* clid_host_model.sv */
/*
   Host processor model on the decoder's parallel bus.
   Assumes the bench calls its tasks one at a time, after reset.
*/
`timescale 1ns/1ns
`default_nettype none
module clid_host_model
(
   input wire logic core_clk,
   output logic hostStrobe,
   output logic registerSelect,
   output logic readNotWrite,
   output logic [7:0] hostDataIn,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataOe,
   input wire logic busyFlag
);
   logic nibbleMode = 1'b0;
   initial
   begin
      hostStrobe = 1'b0;
      registerSelect = 1'b0;
      readNotWrite = 1'b0;
      hostDataIn = 8'h5a;
   end
   // Released data lines show the inverse, so a stale value never matches.
   task automatic strobe1(input logic rs, input logic rw,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge core_clk);
      hostStrobe <= 1'b1;
      registerSelect <= rs;
      readNotWrite <= rw;
      hostDataIn <= d;
      @(posedge core_clk);
      hostStrobe <= 1'b0;
      hostDataIn <= ~d;
      @(posedge core_clk);
      // A read only counts while the device drives the bus.
      #1 q = hostDataOe ? hostDataOut : ~hostDataOut;
      @(posedge core_clk);
      readNotWrite <= 1'b0;
   endtask
   // one strobe per byte, or high nibble then low nibble.
   task automatic xfer(input logic rs, input logic rw,
      input logic [7:0] d, output logic [7:0] q);
      logic [7:0] h;
      logic [7:0] l;
      if (nibbleMode)
      begin
         strobe1(rs, rw, {d[7:4], 4'h0}, h);
         strobe1(rs, rw, {d[3:0], 4'h0}, l);
         q = {h[7:4], l[7:4]};
      end
      else
         strobe1(rs, rw, d, q);
   endtask
   // poll status until idle before the next instruction.
   task automatic waitIdle(output logic ok);
      logic [7:0] s;
      ok = 1'b0;
      for (int n = 0; n < 64 && !ok; n++)
      begin
         xfer(1'b0, 1'b1, 8'h00, s);
         ok = (s[7] === 1'b0);
      end
   endtask
endmodule
`default_nettype wire

/* clid_decoder_test.sv */
/*
   Self-checking bench of the instruction decoder with a host model.
   Assumes shortened execution counts set through the parameters.
*/
`timescale 1ns/1ns
`default_nettype none
module clid_decoder_test;
   logic coreClk = 1'b0;
   logic arstN = 1'b0;
   logic hostStrobe, registerSelect, readNotWrite, hostDataOe, busyFlag;
   logic queueFull, displayBlank, cursorVisible, cursorCellAllOn;
   logic twoLineMode, bigFont, busWidthSelect, glyphHit;
   logic [7:0] hostDataIn, hostDataOut, scanChar;
   logic [6:0] shiftOffset;
   logic [6:0] scanAddr = 7'h00;
   logic [7:0] glyphCode = 8'h00;
   logic [2:0] glyphRowSel = 3'h0;
   logic [4:0] glyphRowBits;
   int failCount = 0;
   int testsRun = 0;
   logic sawFull = 1'b0;
   always #4 coreClk = ~coreClk;
   always @(posedge coreClk)
      if (queueFull === 1'b1)
         sawFull <= 1'b1;
   clid_decoder #(.SHORT_CYCLES(4), .LONG_CYCLES(200), .BLINK_CYCLES(8))
   clid_decoder_i (.core_clk(coreClk), .arst_n(arstN),
      .hostStrobe(hostStrobe), .registerSelect(registerSelect),
      .readNotWrite(readNotWrite), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
      .busyFlag(busyFlag), .queueFull(queueFull),
      .displayBlank(displayBlank), .cursorVisible(cursorVisible),
      .cursorCellAllOn(cursorCellAllOn), .twoLineMode(twoLineMode),
      .bigFont(bigFont), .busWidthSelect(busWidthSelect),
      .shiftOffset(shiftOffset), .scanAddr(scanAddr), .scanChar(scanChar),
      .glyphCode(glyphCode), .glyphRowSel(glyphRowSel),
      .glyphRowBits(glyphRowBits), .glyphHit(glyphHit));
   clid_host_model clid_host_model_i (.core_clk(coreClk),
      .hostStrobe(hostStrobe), .registerSelect(registerSelect),
      .readNotWrite(readNotWrite), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
      .busyFlag(busyFlag));
   task automatic stopTest();
      $display("comparisons %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp)
      begin
         failCount++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Next text address in two-line mode, wrapping between the lines.
   function automatic logic [6:0] nxt(input logic [6:0] a, input logic up);
      if (up)
         return (a == 7'h27) ? 7'h40 : (a == 7'h67) ? 7'h00 : a + 7'h01;
      return (a == 7'h40) ? 7'h27 : (a == 7'h00) ? 7'h67 : a - 7'h01;
   endfunction
   task automatic cmd(input logic rs, input logic rw, input logic [7:0] d,
      output logic [7:0] q);
      logic ok;
      clid_host_model_i.xfer(rs, rw, d, q);
      clid_host_model_i.waitIdle(ok);
      check({7'h00, ok}, 8'h01);
   endtask
   task automatic stat(input logic [7:0] exp);
      logic [7:0] q;
      clid_host_model_i.xfer(1'b0, 1'b1, 8'h00, q);
      check(q, exp);
   endtask
   task automatic scan(input logic [6:0] a, input logic [7:0] gc,
      input logic [2:0] gr);
      @(posedge coreClk);
      scanAddr <= a;
      glyphCode <= gc;
      glyphRowSel <= gr;
      repeat (2) @(posedge coreClk);
      #1;
   endtask
   initial
   begin
      repeat (50000) @(posedge coreClk);
      failCount++;
      stopTest();
   end
   initial
   begin
      logic [7:0] q, d, d0;
      logic ok;
      logic [6:0] a;
      logic [2:0] c, r;
      logic [6:0] corner [4] = '{7'h40, 7'h27, 7'h00, 7'h67};
      logic [7:0] shCode [4] = '{8'h10, 8'h14, 8'h18, 8'h1c};
      logic [6:0] shCtr [4] = '{7'h0f, 7'h10, 7'h10, 7'h10};
      logic [6:0] shOff [4] = '{7'h00, 7'h00, 7'h01, 7'h00};
      void'($urandom(32'h3f72));
      repeat (10) @(posedge coreClk);
      arstN <= 1'b1;
      repeat (3) @(posedge coreClk);
      check({6'h00, displayBlank, busWidthSelect}, 8'h03);
      for (int i = 0; i < 8; i++)
      begin
         cmd(1'b0, 1'b0, 8'h08 | 8'(i), q);
         check({6'h00, displayBlank, cursorVisible},
            {6'h00, ~i[2], i[2] & i[1]});
         q = 8'h00;
         repeat (20)
         begin
            @(posedge coreClk);
            #1 q[0] = q[0] | cursorCellAllOn;
         end
         check(q, {7'h00, i[2] & i[0]});
      end
      for (int j = 0; j < 4; j++)
      begin
         cmd(1'b0, 1'b0, 8'h30 | 8'(j << 2), q);
         check({6'h00, twoLineMode, bigFont}, {6'h00, j[1], j[0]});
      end
      for (int i = 0; i < 10; i++)
      begin
         a = (i < 4) ? corner[i] : 7'($urandom % 40) | {i[0], 6'h00};
         d = 8'($urandom);
         cmd(1'b0, 1'b0, 8'h04 | {6'h00, i[0], 1'b0}, q);
         cmd(1'b0, 1'b0, {1'b1, a}, q);
         stat({1'b0, a});
         cmd(1'b1, 1'b0, d, q);
         stat({1'b0, nxt(a, i[0])});
         scan(a, 8'h00, 3'h0);
         check(scanChar, d);
      end
      cmd(1'b0, 1'b0, 8'h30, q);
      check({7'h00, twoLineMode}, 8'h00);
      cmd(1'b0, 1'b0, 8'h06, q);
      cmd(1'b0, 1'b0, 8'hcf, q);
      cmd(1'b1, 1'b0, 8'h00, q);
      stat(8'h00);
      d0 = 8'($urandom);
      d = 8'($urandom);
      cmd(1'b0, 1'b0, 8'h90, q);
      cmd(1'b1, 1'b0, d0, q);
      cmd(1'b1, 1'b0, d, q);
      cmd(1'b0, 1'b0, 8'h90, q);
      cmd(1'b1, 1'b1, 8'h00, q);
      check(q, d0);
      stat(8'h11);
      cmd(1'b1, 1'b0, d0, q);
      cmd(1'b1, 1'b1, 8'h00, q);
      check(q, d);
      cmd(1'b0, 1'b0, 8'h90, q);
      for (int i = 0; i < 4; i++)
      begin
         cmd(1'b0, 1'b0, shCode[i], q);
         stat({1'b0, shCtr[i]});
         check({1'b0, shiftOffset}, {1'b0, shOff[i]});
      end
      for (int i = 0; i < 4; i++)
      begin
         c = 3'($urandom);
         r = 3'($urandom);
         d = 8'($urandom);
         cmd(1'b0, 1'b0, {2'b01, c, r}, q);
         cmd(1'b1, 1'b0, d, q);
         stat({2'b00, {c, r} + 6'h01});
         scan(7'h00, {4'h0, i[0], c}, r);
         check({glyphHit, 2'h0, glyphRowBits}, {1'b1, 2'h0, d[4:0]});
      end
      // Writes faster than the executor drains them must fill the queue.
      check({7'h00, sawFull}, 8'h00);
      for (int i = 0; i < 100; i++)
         clid_host_model_i.xfer(1'b1, 1'b0, 8'(i), q);
      #1 check({6'h00, sawFull, busyFlag}, 8'h03);
      clid_host_model_i.waitIdle(ok);
      check({5'h00, ok, sawFull, queueFull}, 8'h06);
      // The width change lands before the poll, so polling is in nibbles.
      clid_host_model_i.xfer(1'b0, 1'b0, 8'h28, q);
      clid_host_model_i.nibbleMode = 1'b1;
      clid_host_model_i.waitIdle(ok);
      check({7'h00, ok}, 8'h01);
      check({7'h00, busWidthSelect}, 8'h00);
      d = 8'($urandom);
      cmd(1'b0, 1'b0, 8'h85, q);
      cmd(1'b1, 1'b0, d, q);
      stat(8'h06);
      scan(7'h05, 8'h00, 3'h0);
      check(scanChar, d);
      stopTest();
   end
endmodule
`default_nettype wire
